// *** hw/pwm_common_params.svh ***
// Register offsets, field positions and reset values of the PWM timer common control block.
`ifndef PWM_COMMON_PARAMS_SVH
`define PWM_COMMON_PARAMS_SVH
`define OFS_STOP_CLEAR_SRC 4'h0
`define OFS_WRITE_PROTECT 4'h4
`define OFS_SYNC_CLEAR 4'h8
`define OFS_EXT_TRIG_CTRL 4'hc
`define OFS_BUF_DISABLE 4'h0
`define OFS_BUF_DISABLE_B 4'h0
`define ADR_STOP_CLEAR_SRC 6'h00
`define ADR_WRITE_PROTECT 6'h04
`define ADR_SYNC_CLEAR 6'h08
`define ADR_EXT_TRIG_CTRL 6'h0c
`define ADR_BUF_DISABLE 6'h10
`define POS_CH1_WRITE_LOCK 1
`define POS_CH3_WRITE_LOCK 3
`define POS_TRIG_FILTER_EN 0
`define RST_STOP_CLEAR_SRC 16'h0000
`define RST_WRITE_PROTECT 16'h0000
`define RST_SYNC_CLEAR 16'h3210
`define RST_EXT_TRIG_CTRL 16'h0000
`define RST_BUF_DISABLE 16'h0000
`define WRITE_PROTECT_MASK 16'h000a
`define SYNC_CLEAR_MASK 16'h3333
`define EXT_TRIG_MASK 16'h0001
`define FILTER_SAMPLES 3
`endif

// *** hw/pwm_common_pkg.sv ***
// Types shared by the PWM timer common control block.
package pwm_common_pkg;
    typedef enum logic [3:0] {
        SRC_CMP0 = 4'h0,
        SRC_CMP1 = 4'h1,
        SRC_CMP2 = 4'h4,
        SRC_CMP3 = 4'h5,
        SRC_CH3_PIN_A = 4'h8,
        SRC_CH3_PIN_B = 4'h9,
        SRC_CH3_CMP_A = 4'ha,
        SRC_CH3_CMP_B = 4'hb,
        SRC_EXT_TRIG = 4'hc
    } stop_clear_src_t;
endpackage : pwm_common_pkg

// *** hw/trigger_noise_filter.sv ***
// Majority-free noise filter: the output follows the input after it has been stable.
`timescale 1ns/1ps
`default_nettype none
module trigger_noise_filter #(
    parameter int SAMPLES = 3
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic din,
    output logic dout
);
    logic [SAMPLES-1:0] hist_q;
    logic filt_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            hist_q <= '0;
        end else begin
            hist_q <= {hist_q[SAMPLES-2:0], din};
        end
    end

    // A change is accepted only after every sample in the window agrees.
    always_ff @(posedge clk) begin
        if (rst) begin
            filt_q <= 1'b0;
        end else if (&hist_q) begin
            filt_q <= 1'b1;
        end else if (~|hist_q) begin
            filt_q <= 1'b0;
        end
    end

    assign dout = enable ? filt_q : din;
endmodule : trigger_noise_filter
`default_nettype wire

// *** hw/pwm_timer_common_control.sv ***
// Common control of four PWM timer channels: stop/clear source, sync clear, locks, buffer gates.
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_common_params.svh"

module pwm_timer_common_control
    import pwm_common_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic comparator_0_out,
    input wire logic comparator_1_out,
    input wire logic comparator_2_out,
    input wire logic comparator_3_out,
    input wire logic ch3_io_a,
    input wire logic ch3_io_b,
    input wire logic ch3_cmp_out_a,
    input wire logic ch3_cmp_out_b,
    input wire logic ext_trigger_pin,
    input wire logic [3:0] ch_own_clear,
    input wire logic [3:0] ch_write_req,
    output logic [3:0] ch_write_allow,
    output logic [3:0] hw_stop_clear,
    output logic [3:0] counter_clear,
    output logic [3:0] cmp_buf_off,
    output logic [3:0] period_buf_off,
    output logic [3:0] adc_timing_buf_off,
    output logic [3:0] dead_time_buf_off
);
    // ****************************************************************
    // Registers
    // ****************************************************************
    logic [15:0] stop_clear_src_q;
    logic [15:0] write_protect_q;
    logic [15:0] sync_clear_q;
    logic [15:0] ext_trig_q;
    logic [15:0] buf_disable_q;
    logic wr_en;
    logic rd_sel;
    logic [15:0] wmask;
    logic [15:0] rd_d;

    assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
    assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    always_ff @(posedge clk) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
        end
    end

    always_comb begin
        rd_sel = 1'b1;
        rd_d = 16'h0000;
        unique case (wb_adr_i)
            `ADR_STOP_CLEAR_SRC: rd_d = stop_clear_src_q;
            `ADR_WRITE_PROTECT: rd_d = write_protect_q;
            `ADR_SYNC_CLEAR: rd_d = sync_clear_q;
            `ADR_EXT_TRIG_CTRL: rd_d = ext_trig_q;
            `ADR_BUF_DISABLE: rd_d = buf_disable_q;
            default: rd_sel = 1'b0;
        endcase
    end

    // Unmapped addresses still acknowledge and read as zero so the bus never hangs.
    always_ff @(posedge clk) begin
        if (rst) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
            wb_dat_o <= rd_sel ? {16'h0000, rd_d} : 32'h0000_0000;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            stop_clear_src_q <= `RST_STOP_CLEAR_SRC;
        end else if (wr_en && wb_adr_i == `ADR_STOP_CLEAR_SRC) begin
            stop_clear_src_q <= (stop_clear_src_q & ~wmask) | (wb_dat_i[15:0] & wmask);
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            write_protect_q <= `RST_WRITE_PROTECT;
        end else if (wr_en && wb_adr_i == `ADR_WRITE_PROTECT) begin
            write_protect_q <= ((write_protect_q & ~wmask) | (wb_dat_i[15:0] & wmask))
                & `WRITE_PROTECT_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            sync_clear_q <= `RST_SYNC_CLEAR;
        end else if (wr_en && wb_adr_i == `ADR_SYNC_CLEAR) begin
            sync_clear_q <= ((sync_clear_q & ~wmask) | (wb_dat_i[15:0] & wmask))
                & `SYNC_CLEAR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ext_trig_q <= `RST_EXT_TRIG_CTRL;
        end else if (wr_en && wb_adr_i == `ADR_EXT_TRIG_CTRL) begin
            ext_trig_q <= ((ext_trig_q & ~wmask) | (wb_dat_i[15:0] & wmask))
                & `EXT_TRIG_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            buf_disable_q <= `RST_BUF_DISABLE;
        end else if (wr_en && wb_adr_i == `ADR_BUF_DISABLE) begin
            buf_disable_q <= (buf_disable_q & ~wmask) | (wb_dat_i[15:0] & wmask);
        end
    end

    // ****************************************************************
    // Write locks and buffer gates
    // ****************************************************************
    logic ch1_write_lock;
    logic ch3_write_lock;
    assign ch1_write_lock = write_protect_q[`POS_CH1_WRITE_LOCK];
    assign ch3_write_lock = write_protect_q[`POS_CH3_WRITE_LOCK];
    // Channel 0 and 2 locks are not provided; their paired long-word views fall under 1 and 3.
    assign ch_write_allow[0] = ch_write_req[0];
    assign ch_write_allow[1] = ch_write_req[1] && !ch1_write_lock;
    assign ch_write_allow[2] = ch_write_req[2];
    assign ch_write_allow[3] = ch_write_req[3] && !ch3_write_lock;

    generate
        for (genvar c = 0; c < 4; c++) begin : g_buf
            assign cmp_buf_off[c] = buf_disable_q[4*c];
            assign period_buf_off[c] = buf_disable_q[4*c+1];
            assign adc_timing_buf_off[c] = buf_disable_q[4*c+2];
            assign dead_time_buf_off[c] = buf_disable_q[4*c+3];
        end
    endgenerate

    // ****************************************************************
    // Pin synchronisers and trigger filter
    // ****************************************************************
    logic [6:0] pin_s1_q;
    logic [6:0] pin_s2_q;
    logic trig_filtered;

    always_ff @(posedge clk) begin
        if (rst) begin
            pin_s1_q <= 7'h00;
            pin_s2_q <= 7'h00;
        end else begin
            pin_s1_q <= {ext_trigger_pin, ch3_io_b, ch3_io_a, comparator_3_out,
                comparator_2_out, comparator_1_out, comparator_0_out};
            pin_s2_q <= pin_s1_q;
        end
    end

    trigger_noise_filter #(
        .SAMPLES(`FILTER_SAMPLES)
    ) u_trig_filter (
        .clk(clk),
        .rst(rst),
        .enable(ext_trig_q[`POS_TRIG_FILTER_EN]),
        .din(pin_s2_q[6]),
        .dout(trig_filtered)
    );

    // ****************************************************************
    // Source selection and synchronous clear
    // ****************************************************************
    function automatic logic pick_src(input logic [3:0] code, input logic [6:0] pins,
            input logic trig, input logic cmp_a, input logic cmp_b);
        logic r;
        r = 1'b0;
        // Unlisted codes select nothing; software must avoid them anyway.
        case (code)
            SRC_CMP0: r = pins[0];
            SRC_CMP1: r = pins[1];
            SRC_CMP2: r = pins[2];
            SRC_CMP3: r = pins[3];
            SRC_CH3_PIN_A: r = pins[4];
            SRC_CH3_PIN_B: r = pins[5];
            SRC_CH3_CMP_A: r = cmp_a;
            SRC_CH3_CMP_B: r = cmp_b;
            SRC_EXT_TRIG: r = trig;
            default: r = 1'b0;
        endcase
        return r;
    endfunction : pick_src

    logic [3:0] clear_src;
    generate
        for (genvar c = 0; c < 4; c++) begin : g_src
            // Fields at 3:0, 7:4, 11:8, 15:12.
            assign hw_stop_clear[c] = pick_src(stop_clear_src_q[4*c+3:4*c], pin_s2_q,
                trig_filtered, ch3_cmp_out_a, ch3_cmp_out_b);
            assign clear_src[c] = hw_stop_clear[c] || ch_own_clear[c];
        end
    endgenerate

    // A field equal to the channel's own index means "no synchronous clear".
    // Followers see only the source's own and stop/clear-source clears, never its sync clear, so chains cannot loop.
    generate
        for (genvar c = 0; c < 4; c++) begin : g_sync
            logic [1:0] sel;
            assign sel = sync_clear_q[4*c+1:4*c];
            assign counter_clear[c] = clear_src[c] ||
                ((sel != 2'(c)) && clear_src[sel]);
        end
    endgenerate

    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_lock_ch1_blocks: assert property (@(posedge clk) disable iff (rst)
        ch1_write_lock |-> !ch_write_allow[1])
        else $error("channel 1 write passed while locked");
    a_lock_ch3_blocks: assert property (@(posedge clk) disable iff (rst)
        ch3_write_lock |-> !ch_write_allow[3])
        else $error("channel 3 write passed while locked");
    a_ch0_follow_ch3: assert property (@(posedge clk) disable iff (rst)
        (sync_clear_q[1:0] == 2'b11 && clear_src[3]) |-> counter_clear[0])
        else $error("channel 0 missed sync clear from channel 3");
    a_ch0_none: assert property (@(posedge clk) disable iff (rst)
        (sync_clear_q[1:0] == 2'b00 && !clear_src[0]) |-> !counter_clear[0])
        else $error("channel 0 cleared without source");
    a_ch1_follow_ch0: assert property (@(posedge clk) disable iff (rst)
        (sync_clear_q[5:4] == 2'b00 && clear_src[0]) |-> counter_clear[1])
        else $error("channel 1 missed sync clear from channel 0");
    a_ch2_follow_ch1: assert property (@(posedge clk) disable iff (rst)
        (sync_clear_q[9:8] == 2'b01 && clear_src[1]) |-> counter_clear[2])
        else $error("channel 2 missed sync clear from channel 1");
    a_ch3_none: assert property (@(posedge clk) disable iff (rst)
        (sync_clear_q[13:12] == 2'b11 && !clear_src[3]) |-> !counter_clear[3])
        else $error("channel 3 cleared without source");
    a_ch3_ext_trig: assert property (@(posedge clk) disable iff (rst)
        (stop_clear_src_q[15:12] == 4'hc && !ext_trig_q[0] && pin_s2_q[6])
        |-> hw_stop_clear[3])
        else $error("external trigger not routed to channel 3");
    a_ch3_cmp2_src: assert property (@(posedge clk) disable iff (rst)
        (stop_clear_src_q[15:12] == 4'h4) |-> (hw_stop_clear[3] == pin_s2_q[2]))
        else $error("comparator 2 not routed to channel 3");
    a_buf_cmp_gate: assert property (@(posedge clk) disable iff (rst)
        (wr_en && wb_adr_i == `ADR_BUF_DISABLE && wb_sel_i[0])
        |=> (cmp_buf_off[0] == $past(wb_dat_i[0])))
        else $error("compare buffer gate did not follow write");
    // Sync-clear checks cover a follow and a no-clear encoding of every channel.
    a_ch0_follow_ch1: assert property (@(posedge clk) disable iff (rst)
        (sync_clear_q[1:0] == 2'b01 && clear_src[1]) |-> counter_clear[0])
        else $error("channel 0 missed sync clear from channel 1");
    a_ch1_none: assert property (@(posedge clk) disable iff (rst)
        (sync_clear_q[5:4] == 2'b01 && !clear_src[1]) |-> !counter_clear[1])
        else $error("channel 1 cleared without source");
    a_ch2_none: assert property (@(posedge clk) disable iff (rst)
        (sync_clear_q[9:8] == 2'b10 && !clear_src[2]) |-> !counter_clear[2])
        else $error("channel 2 cleared without source");
    a_ch2_follow_ch3: assert property (@(posedge clk) disable iff (rst)
        (sync_clear_q[9:8] == 2'b11 && clear_src[3]) |-> counter_clear[2])
        else $error("channel 2 missed sync clear from channel 3");
    a_ch3_follow_ch2: assert property (@(posedge clk) disable iff (rst)
        (sync_clear_q[13:12] == 2'b10 && clear_src[2]) |-> counter_clear[3])
        else $error("channel 3 missed sync clear from channel 2");
    a_ch3_pin_a: assert property (@(posedge clk) disable iff (rst)
        (stop_clear_src_q[15:12] == 4'h8) |-> (hw_stop_clear[3] == pin_s2_q[4]))
        else $error("pin A input not routed to channel 3");
    a_ch3_cmp_b: assert property (@(posedge clk) disable iff (rst)
        (stop_clear_src_q[15:12] == 4'hb) |-> (hw_stop_clear[3] == ch3_cmp_out_b))
        else $error("compare output B not routed to channel 3");
    a_buf_dead_gate: assert property (@(posedge clk) disable iff (rst)
        (wr_en && wb_adr_i == `ADR_BUF_DISABLE && wb_sel_i[1])
        |=> (dead_time_buf_off[3] == $past(wb_dat_i[15])))
        else $error("dead-time buffer gate did not follow write");
    a_filter_bypass: assert property (@(posedge clk) disable iff (rst)
        !ext_trig_q[0] |-> (trig_filtered == pin_s2_q[6]))
        else $error("unfiltered trigger does not follow its pin");
    a_ack_one_cycle: assert property (@(posedge clk) disable iff (rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
endmodule : pwm_timer_common_control
`default_nettype wire

// *** dv/pwm_pin_partner.sv ***
// Behavioural model of the comparators, capture pins, channel 3 compare outputs and trigger pin.
`timescale 1ns/1ps
`default_nettype none
module pwm_pin_partner (
    input wire logic clk,
    input wire logic [8:0] level,
    output logic comparator_0_out,
    output logic comparator_1_out,
    output logic comparator_2_out,
    output logic comparator_3_out,
    output logic ch3_io_a,
    output logic ch3_io_b,
    output logic ch3_cmp_out_a,
    output logic ch3_cmp_out_b,
    output logic ext_trigger_pin
);
    // The levels are registered on each rising edge, so they change in step with the clock, one cycle after level.
    logic [8:0] pins_q;
    always_ff @(posedge clk) begin
        pins_q <= level;
    end
    assign comparator_0_out = pins_q[0];
    assign comparator_1_out = pins_q[1];
    assign comparator_2_out = pins_q[2];
    assign comparator_3_out = pins_q[3];
    assign ch3_io_a = pins_q[4];
    assign ch3_io_b = pins_q[5];
    assign ch3_cmp_out_a = pins_q[6];
    assign ch3_cmp_out_b = pins_q[7];
    assign ext_trigger_pin = pins_q[8];
endmodule : pwm_pin_partner
`default_nettype wire

// *** dv/pwm_timer_common_control_tb_top.sv ***
// Self-checking testbench of the PWM timer common control block.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_common_params.svh"
module pwm_timer_common_control_tb_top
    import pwm_common_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic [5:0] wb_adr = 6'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0000_0000;
    logic [31:0] wb_q;
    logic wb_ack;
    logic [8:0] src_level = 9'h000;
    logic [3:0] own = 4'h0, wreq = 4'h0, allow, hw_sc, cclr, b_cmp, b_per, b_adc, b_dt, seen;
    logic c0, c1, c2, c3, pa, pb, ca, cb, tr;
    int fails = 0;
    int check_count = 0;
    stop_clear_src_t codes [9] = '{SRC_CMP0, SRC_CMP1, SRC_CMP2, SRC_CMP3, SRC_CH3_PIN_A,
        SRC_CH3_PIN_B, SRC_CH3_CMP_A, SRC_CH3_CMP_B, SRC_EXT_TRIG};
    always #12.5 clk = ~clk;
    pwm_pin_partner i_partner (.clk(clk), .level(src_level), .comparator_0_out(c0),
        .comparator_1_out(c1), .comparator_2_out(c2), .comparator_3_out(c3), .ch3_io_a(pa),
        .ch3_io_b(pb), .ch3_cmp_out_a(ca), .ch3_cmp_out_b(cb), .ext_trigger_pin(tr));
    pwm_timer_common_control i_dut (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_q), .wb_ack_o(wb_ack), .comparator_0_out(c0), .comparator_1_out(c1),
        .comparator_2_out(c2), .comparator_3_out(c3), .ch3_io_a(pa), .ch3_io_b(pb),
        .ch3_cmp_out_a(ca), .ch3_cmp_out_b(cb), .ext_trigger_pin(tr), .ch_own_clear(own),
        .ch_write_req(wreq), .ch_write_allow(allow), .hw_stop_clear(hw_sc),
        .counter_clear(cclr), .cmp_buf_off(b_cmp), .period_buf_off(b_per),
        .adc_timing_buf_off(b_adc), .dead_time_buf_off(b_dt));
    // ************************************************************
    // Bus cycles and comparisons
    // ************************************************************
    task automatic report_and_stop();
        if (fails == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : report_and_stop
    task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_reg
    task automatic cmp_port(input logic [3:0] got, input logic [3:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_port
    // The master waits for ack without assuming a latency; only the bound ends a hang.
    task automatic wb_cycle(input logic we, input logic [5:0] a, input logic [15:0] d,
                            input logic [3:0] s, output logic [31:0] q);
        int n;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_sel <= s;
        wb_dat <= {16'h0000, d};
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack !== 1'b1 && n < 50);
        q = wb_q;
        if (n >= 50) begin
            fails++;
            report_and_stop();
        end
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb_cycle
    task automatic wr(input logic [5:0] a, input logic [15:0] d, input logic [3:0] s = 4'h3);
        logic [31:0] q;
        wb_cycle(1'b1, a, d, s, q);
    endtask : wr
    task automatic rd_check(input logic [5:0] a, input logic [15:0] exp);
        logic [31:0] q;
        wb_cycle(1'b0, a, 16'h0000, 4'h3, q);
        cmp_reg(q[31:16], 16'h0000);
        cmp_reg(q[15:0], exp);
    endtask : rd_check
    task automatic trig_pulse();
        seen = 4'h0;
        @(posedge clk);
        src_level <= 9'h100;
        @(posedge clk);
        src_level <= 9'h000;
        repeat (12) begin
            @(negedge clk);
            seen = seen | hw_sc;
        end
    endtask : trig_pulse
    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        #(25 * 20000);
        fails++;
        report_and_stop();
    end
    initial begin
        logic [3:0] sv, ev;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd_check(`ADR_STOP_CLEAR_SRC, `RST_STOP_CLEAR_SRC);
        rd_check(`ADR_WRITE_PROTECT, `RST_WRITE_PROTECT);
        rd_check(`ADR_SYNC_CLEAR, `RST_SYNC_CLEAR);
        rd_check(`ADR_EXT_TRIG_CTRL, `RST_EXT_TRIG_CTRL);
        rd_check(`ADR_BUF_DISABLE, `RST_BUF_DISABLE);
        wr(6'h14, 16'hffff);
        rd_check(6'h14, 16'h0000);
        // Only listed codes are ever programmed while sources are live.
        for (int i = 0; i < 9; i++) begin
            wr(`ADR_STOP_CLEAR_SRC, {4{codes[i]}});
            rd_check(`ADR_STOP_CLEAR_SRC, {4{codes[i]}});
            @(posedge clk) src_level <= 9'h001 << i;
            repeat (6) @(negedge clk);
            cmp_port(hw_sc, 4'hf);
            @(posedge clk) src_level <= ~(9'h001 << i);
            repeat (6) @(negedge clk);
            cmp_port(hw_sc, 4'h0);
        end
        @(posedge clk) src_level <= 9'h000;
        repeat (6) @(posedge clk);
        trig_pulse();
        cmp_port(seen, 4'hf);
        wr(`ADR_EXT_TRIG_CTRL, 16'hffff);
        rd_check(`ADR_EXT_TRIG_CTRL, 16'h0001);
        trig_pulse();
        cmp_port(seen, 4'h0);
        // A held trigger passes the filter, but later than the unfiltered path would.
        @(posedge clk) src_level <= 9'h100;
        repeat (5) @(negedge clk);
        cmp_port(hw_sc, 4'h0);
        repeat (7) @(negedge clk);
        cmp_port(hw_sc, 4'hf);
        @(posedge clk) src_level <= 9'h000;
        repeat (12) @(negedge clk);
        cmp_port(hw_sc, 4'h0);
        @(posedge clk) wreq <= 4'hf;
        for (int w = 0; w < 4; w++) begin
            wr(`ADR_WRITE_PROTECT, {12'h000, w[1], 1'b0, w[0], 1'b0});
            @(negedge clk);
            cmp_port(allow, {~w[1], 1'b1, ~w[0], 1'b1});
        end
        wr(`ADR_WRITE_PROTECT, 16'hffff);
        rd_check(`ADR_WRITE_PROTECT, 16'h000a);
        // A channel whose select equals its own number has no synchronous clear.
        for (int s = 0; s < 4; s++) begin
            sv = 4'(s);
            wr(`ADR_SYNC_CLEAR, {4{2'b00, sv[1:0]}});
            for (int j = 0; j < 4; j++) begin
                @(posedge clk) own <= 4'h1 << j;
                @(negedge clk);
                ev = (4'h1 << j) | ((j != s) ? 4'h0 : ~(4'h1 << s));
                cmp_port(cclr & 4'h1, ev & 4'h1);
                cmp_port(cclr & 4'h2, ev & 4'h2);
                cmp_port(cclr & 4'h4, ev & 4'h4);
                cmp_port(cclr & 4'h8, ev & 4'h8);
            end
            @(posedge clk) own <= 4'h0;
        end
        wr(`ADR_SYNC_CLEAR, 16'h0000, 4'h2);
        rd_check(`ADR_SYNC_CLEAR, 16'h0033);
        wr(`ADR_BUF_DISABLE, 16'ha5c3);
        rd_check(`ADR_BUF_DISABLE, 16'ha5c3);
        @(negedge clk);
        cmp_port(b_cmp, 4'b0101);
        cmp_port(b_per, 4'b1001);
        cmp_port(b_adc, 4'b0110);
        cmp_port(b_dt, 4'b1010);
        // A second reset in mid-run puts every register back to its reset value.
        @(posedge clk) rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_check(`ADR_BUF_DISABLE, `RST_BUF_DISABLE);
        rd_check(`ADR_SYNC_CLEAR, `RST_SYNC_CLEAR);
        @(negedge clk);
        cmp_port(b_dt, 4'h0);
        cmp_port(allow, 4'hf);
        report_and_stop();
    end
endmodule : pwm_timer_common_control_tb_top
`default_nettype wire
